// ---- core/sss_ctrl.sv ----
// Purpose: Start-up, sync and operating-state controller with Wishbone slave
// Assumes: Host sync requests come from logic on clk_sys
// Notes: All state lives in one struct, registered in one process
`timescale 1ns/1ps
module sss_ctrl #(
  parameter int BOOT_CYC = sss_pkg::BOOT_CYC,
  parameter int HW_CYC = sss_pkg::HW_CYC,
  parameter int MEM_CYC = sss_pkg::MEM_CYC,
  parameter int DRV_CYC = sss_pkg::DRV_CYC,
  parameter int BLINK_CYC = sss_pkg::BLINK_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Front switch pin and resource status
  input wire logic run_switch,
  input wire logic res_short,
  // Host synchronisation
  input wire logic sync_req,
  input wire logic [2:0] sync_frame,
  output logic sync_done,
  output logic [7:0] config_error_byte,
  // Status outputs
  output logic traffic_en,
  output logic conn_drop,
  output logic cfg_load_ok,
  output logic cold_restart,
  output logic lamp_run,
  output logic lamp_stop,
  output logic comm_lamp,
  output logic irq
);

  // ****************************************
  // State record
  // ****************************************
  typedef struct packed {
    sss_pkg::sss_state_t st;
    logic [31:0] cnt;
    logic [31:0] blink_cnt;
    logic blink;
    logic sw_s1;
    logic sw_s2;
    logic sw_s3;
    logic sw_run;
    logic sw_run_d;
    logic tool_stop;
    logic [7:0] frames;
    logic [7:0] synced;
    logic [sss_pkg::NEV-1:0] irq_stat;
    logic [sss_pkg::NEV-1:0] irq_mask;
    logic ack;
    logic [31:0] dat;
    logic sync_done;
    logic [7:0] err;
    logic traffic_en;
    logic conn_drop;
    logic cold;
    logic cfg_ok;
    logic l_run;
    logic l_stop;
    logic l_com;
    logic irq;
  } sss_reg_t;

  sss_reg_t q_r;
  sss_reg_t q_nxt;

  logic all_synced;
  logic eff_run;
  logic restart;
  logic restart_cold;
  logic wr;
  logic rstall;
  logic [sss_pkg::NEV-1:0] ev;
  logic [31:0] rd;

  assign all_synced = (q_r.synced & q_r.frames) == q_r.frames;
  assign eff_run = q_r.sw_run & ~q_r.tool_stop;
  assign wr = q_r.ack & wb_cyc_i & wb_stb_i & wb_we_i;
  assign rstall = wr && wb_adr_i == sss_pkg::A_CTRL && wb_sel_i[0] && wb_dat_i[sss_pkg::CTRL_RSTALL];

  // ****************************************
  // Read mux
  // ****************************************
  always_comb begin
    rd = 32'h0000_0000;
    case (wb_adr_i)
      sss_pkg::A_CTRL: rd[sss_pkg::CTRL_TSTOP] = q_r.tool_stop;
      sss_pkg::A_FRAMES: rd[7:0] = q_r.frames;
      sss_pkg::A_STATUS: begin
        rd[sss_pkg::ST_STATE +: 7] = q_r.st;
        rd[sss_pkg::ST_SW] = q_r.sw_run;
        rd[sss_pkg::ST_ALL] = all_synced;
        rd[sss_pkg::ST_SYNC +: 8] = q_r.synced;
      end
      sss_pkg::A_IRQ_STAT: rd[sss_pkg::NEV-1:0] = q_r.irq_stat;
      sss_pkg::A_IRQ_MASK: rd[sss_pkg::NEV-1:0] = q_r.irq_mask;
      sss_pkg::A_ERRBYTE: rd[7:0] = q_r.err;
      default: rd = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    q_nxt = q_r;
    ev = '0;
    restart = 1'b0;
    restart_cold = 1'b0;
    q_nxt.sync_done = 1'b0;
    q_nxt.conn_drop = 1'b0;
    q_nxt.cold = 1'b0;

    // Switch pin: three flops, accept once the last two agree
    q_nxt.sw_s1 = run_switch;
    q_nxt.sw_s2 = q_r.sw_s1;
    q_nxt.sw_s3 = q_r.sw_s2;
    if (q_r.sw_s2 == q_r.sw_s3) begin
      q_nxt.sw_run = q_r.sw_s3;
    end
    q_nxt.sw_run_d = q_r.sw_run;

    // Wishbone: ack one cycle after request, writes at the acked edge
    q_nxt.ack = wb_cyc_i & wb_stb_i & ~q_r.ack;
    q_nxt.dat = (wb_cyc_i & wb_stb_i & ~q_r.ack) ? rd : 32'h0000_0000;
    if (wr && wb_sel_i[0]) begin
      case (wb_adr_i)
        sss_pkg::A_CTRL: begin
          if (q_r.sw_run) begin
            q_nxt.tool_stop = wb_dat_i[sss_pkg::CTRL_TSTOP];
          end
        end
        sss_pkg::A_FRAMES: begin
          if (q_r.st == sss_pkg::S_STOP) begin
            q_nxt.frames = wb_dat_i[7:0];
          end
        end
        sss_pkg::A_IRQ_MASK: q_nxt.irq_mask = wb_dat_i[sss_pkg::NEV-1:0];
        default: ;
      endcase
    end

    // Blink timebase for the comm lamp
    if (q_r.blink_cnt >= BLINK_CYC - 1) begin
      q_nxt.blink_cnt = 32'h0000_0000;
      q_nxt.blink = ~q_r.blink;
    end else begin
      q_nxt.blink_cnt = q_r.blink_cnt + 32'h0000_0001;
    end

    // Host sync requests: error byte stays nonzero until boot is done
    if (sync_req) begin
      q_nxt.sync_done = 1'b1;
      if (q_r.st inside {sss_pkg::S_HW, sss_pkg::S_MEM, sss_pkg::S_DRV, sss_pkg::S_JOB}) begin
        q_nxt.err = sss_pkg::ERR_BOOT;
      end else if (!q_r.frames[sync_frame]) begin
        q_nxt.err = sss_pkg::ERR_FRAME;
      end else if (q_r.st == sss_pkg::S_RUN) begin
        q_nxt.err = sss_pkg::ERR_NONE;
        restart = 1'b1;
      end else begin
        q_nxt.err = sss_pkg::ERR_NONE;
        q_nxt.synced[sync_frame] = 1'b1;
        ev[sss_pkg::EV_SYNC] = 1'b1;
      end
    end

    // Operating states
    case (q_r.st)
      sss_pkg::S_HW, sss_pkg::S_MEM, sss_pkg::S_DRV, sss_pkg::S_JOB: begin
        q_nxt.cnt = q_r.cnt + 32'h0000_0001;
        if (q_r.st == sss_pkg::S_HW && q_r.cnt >= HW_CYC - 1) begin
          q_nxt.st = sss_pkg::S_MEM;
        end
        if (q_r.st == sss_pkg::S_MEM && q_r.cnt >= MEM_CYC - 1) begin
          q_nxt.st = sss_pkg::S_DRV;
        end
        if (q_r.st == sss_pkg::S_DRV && q_r.cnt >= DRV_CYC - 1) begin
          q_nxt.st = sss_pkg::S_JOB;
        end
        if (q_r.st == sss_pkg::S_JOB && q_r.cnt >= BOOT_CYC - 1 && !res_short) begin
          q_nxt.st = eff_run ? sss_pkg::S_IDLE : sss_pkg::S_STOP;
          q_nxt.cnt = 32'h0000_0000;
          ev[sss_pkg::EV_BOOT] = 1'b1;
        end
        q_nxt.cnt = (q_nxt.st != q_r.st && q_nxt.st == sss_pkg::S_IDLE) ? 32'h0000_0000 : q_nxt.cnt;
        if (q_r.cnt >= BOOT_CYC - 1) begin
          q_nxt.cnt = q_r.cnt;
        end
      end
      sss_pkg::S_IDLE: begin
        if (!eff_run) begin
          q_nxt.st = sss_pkg::S_STOP;
        end else if (all_synced) begin
          q_nxt.st = sss_pkg::S_RUN;
          ev[sss_pkg::EV_ALL] = 1'b1;
        end
      end
      sss_pkg::S_RUN: begin
        if (!eff_run) begin
          q_nxt.st = sss_pkg::S_STOP;
        end
      end
      sss_pkg::S_STOP: begin
        if (eff_run) begin
          restart = 1'b1;
          restart_cold = ~q_r.sw_run_d;
        end
      end
      default: begin
        q_nxt.st = sss_pkg::S_HW;
        q_nxt.cnt = 32'h0000_0000;
      end
    endcase

    // Reset-all from software forces a warm restart
    if (rstall) begin
      restart = 1'b1;
      restart_cold = 1'b0;
    end

    // Restart: drop links, clear flags, re-run the boot
    if (restart) begin
      q_nxt.conn_drop = 1'b1;
      q_nxt.cold = restart_cold;
      q_nxt.synced = 8'h00;
      q_nxt.err = sss_pkg::ERR_BOOT;
      ev[sss_pkg::EV_RESTART] = 1'b1;
      if (restart_cold) begin
        q_nxt.st = sss_pkg::S_HW;
        q_nxt.cnt = 32'h0000_0000;
      end else begin
        q_nxt.st = sss_pkg::S_JOB;
        q_nxt.cnt = DRV_CYC;
      end
    end

    q_nxt.cfg_ok = q_nxt.st == sss_pkg::S_STOP;

    // Lamps and traffic follow the next state, in step with the load flag
    case (q_nxt.st)
      sss_pkg::S_IDLE: begin
        q_nxt.traffic_en = 1'b0;
        q_nxt.l_run = 1'b1;
        q_nxt.l_stop = 1'b1;
        q_nxt.l_com = 1'b0;
      end
      sss_pkg::S_RUN: begin
        q_nxt.traffic_en = 1'b1;
        q_nxt.l_run = 1'b1;
        q_nxt.l_stop = 1'b0;
        q_nxt.l_com = 1'b0;
      end
      sss_pkg::S_JOB: begin
        q_nxt.traffic_en = 1'b0;
        q_nxt.l_run = eff_run;
        q_nxt.l_stop = 1'b1;
        q_nxt.l_com = res_short & q_r.blink;
      end
      default: begin
        q_nxt.traffic_en = 1'b0;
        q_nxt.l_run = 1'b0;
        q_nxt.l_stop = 1'b1;
        q_nxt.l_com = 1'b0;
      end
    endcase

    // Sticky events: a new event wins over a write-one clear
    if (wr && wb_sel_i[0] && wb_adr_i == sss_pkg::A_IRQ_STAT) begin
      q_nxt.irq_stat = q_r.irq_stat & ~wb_dat_i[sss_pkg::NEV-1:0];
    end
    q_nxt.irq_stat = q_nxt.irq_stat | ev;
    q_nxt.irq = |(q_nxt.irq_stat & q_nxt.irq_mask);
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q_r <= '0;
      q_r.st <= sss_pkg::S_HW;
      q_r.frames <= sss_pkg::FRAMES_RST;
      q_r.err <= sss_pkg::ERR_BOOT;
      q_r.l_stop <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign wb_dat_o = q_r.dat;
  assign wb_ack_o = q_r.ack;
  assign sync_done = q_r.sync_done;
  assign config_error_byte = q_r.err;
  assign traffic_en = q_r.traffic_en;
  assign conn_drop = q_r.conn_drop;
  assign cfg_load_ok = q_r.cfg_ok;
  assign cold_restart = q_r.cold;
  assign lamp_run = q_r.l_run;
  assign lamp_stop = q_r.l_stop;
  assign comm_lamp = q_r.l_com;
  assign irq = q_r.irq;

endmodule : sss_ctrl

// ---- core/sss_pkg.sv ----
// Purpose: Constants and types for the start-up and state controller
// Assumes: 100 MHz clk_sys, classic Wishbone register access
// Notes: Byte addresses, one 32-bit word per register
//
// What this block does
// - Boot runs hardware, memory, driver setup first
// - No frame service until ten-second boot done
// - Post-boot unsynced, switch at run: block traffic, idle, both lamps
// - Resync while running may reboot the device
// - Every stop-to-run change after boot restarts, dropping connections
// - Switch toggle cold; resync, tool, reset-all warm
// - Unsynced: switch stop gives stop, run gives idle
// - Synced: switch stop gives stop, run gives run
// - Lacking resources at job start: comm lamp blinks
// - Idle: await sync, comm lamp off, traffic blocked
// - Run only when all frames synced; run lamp
// - Stop: traffic blocked, stop lamp, config load allowed
package sss_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int BOOT_S = 10;
  localparam int HW_MS = 100;
  localparam int MEM_MS = 2000;
  localparam int DRV_MS = 500;
  localparam int BLINK_MS = 250;
  localparam int BOOT_CYC = BOOT_S * CLK_HZ;
  localparam int HW_CYC = HW_MS * (CLK_HZ / 1000);
  localparam int MEM_CYC = HW_CYC + MEM_MS * (CLK_HZ / 1000);
  localparam int DRV_CYC = MEM_CYC + DRV_MS * (CLK_HZ / 1000);
  localparam int BLINK_CYC = BLINK_MS * (CLK_HZ / 1000);
  localparam int NFRM = 8;
  // Register byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_FRAMES = 8'h04;
  localparam logic [7:0] A_STATUS = 8'h08;
  localparam logic [7:0] A_IRQ_STAT = 8'h0C;
  localparam logic [7:0] A_IRQ_MASK = 8'h10;
  localparam logic [7:0] A_ERRBYTE = 8'h14;
  // Control fields
  localparam int CTRL_TSTOP = 0;
  localparam int CTRL_RSTALL = 1;
  // Status fields
  localparam int ST_STATE = 0;
  localparam int ST_SW = 8;
  localparam int ST_ALL = 9;
  localparam int ST_SYNC = 16;
  // Interrupt events
  localparam int EV_BOOT = 0;
  localparam int EV_SYNC = 1;
  localparam int EV_RESTART = 2;
  localparam int EV_ALL = 3;
  localparam int NEV = 4;
  // Reset values and error byte codes
  localparam logic [7:0] FRAMES_RST = 8'h01;
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_BOOT = 8'h01;
  localparam logic [7:0] ERR_FRAME = 8'h02;
  typedef enum logic [6:0] {
    S_HW = 7'h01,
    S_MEM = 7'h02,
    S_DRV = 7'h04,
    S_JOB = 7'h08,
    S_IDLE = 7'h10,
    S_STOP = 7'h20,
    S_RUN = 7'h40
  } sss_state_t;
endpackage : sss_pkg

// ---- testbench/sss_host_model.sv ----
// Purpose: Host controller model issuing frame sync requests
// Assumes: Answer comes one cycle after the request
// Notes: Poll limit stands in for the host timeout
`timescale 1ns/1ps
module sss_host_model #(
  parameter int POLL_MAX = 60
) (
  // Answer from the block
  input wire logic clk_sys,
  input wire logic sync_done,
  input wire logic [7:0] config_error_byte,
  // Request to the block
  output logic sync_req,
  output logic [2:0] sync_frame
);
  initial begin
    sync_req = 1'b0;
    sync_frame = 3'h0;
  end
  task automatic sync(input logic [2:0] f, output logic [7:0] e, output logic d);
    @(posedge clk_sys);
    sync_req <= 1'b1;
    sync_frame <= f;
    @(posedge clk_sys);
    sync_req <= 1'b0;
    sync_frame <= ~f;
    #1;
    e = config_error_byte;
    d = sync_done;
  endtask : sync
  task automatic poll(input logic [2:0] f, output logic ok);
    logic [7:0] e;
    logic d;
    ok = 1'b0;
    for (int n = 0; n < POLL_MAX && !ok; n++) begin
      sync(f, e, d);
      ok = (e === 8'h00);
      if (!ok) repeat (6) @(posedge clk_sys);
    end
  endtask : poll
endmodule : sss_host_model

// ---- testbench/sss_ctrl_checker.sv ----
// Purpose: Port assertions for the state controller
// Assumes: One clock domain
// Notes: Bound to sss_ctrl
`timescale 1ns/1ps
module sss_ctrl_checker #(
  parameter int BOOT_CYC = 200
) (
  // Watched ports
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic sync_req,
  input wire logic sync_done,
  input wire logic [7:0] config_error_byte,
  input wire logic traffic_en,
  input wire logic conn_drop,
  input wire logic cfg_load_ok,
  input wire logic cold_restart,
  input wire logic lamp_run,
  input wire logic lamp_stop,
  input wire logic comm_lamp
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [15:0] boot_cnt_r;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      boot_cnt_r <= 16'h0000;
    end else if (boot_cnt_r != 16'hFFFF) begin
      boot_cnt_r <= boot_cnt_r + 16'h0001;
    end
  end
  sequence wb_req_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence ack_pulse_s; wb_ack_o ##1 !wb_ack_o; endsequence
  wb_ack_a: assert property (wb_req_s |=> ack_pulse_s) else $error("bad ack");
  sync_reply_a: assert property (sync_req |=> sync_done) else $error("no sync_done");
  boot_block_a: assert property (int'(boot_cnt_r) < BOOT_CYC - 2 |->
    config_error_byte == 8'h01 && !traffic_en) else $error("early service");
  start_lamps_a: assert property (boot_cnt_r < 16'h0008 |->
    lamp_stop && !lamp_run && !comm_lamp) else $error("start lamps");
  run_lamps_a: assert property (traffic_en |-> lamp_run && !lamp_stop && !comm_lamp)
    else $error("run lamps");
  stop_lamps_a: assert property (cfg_load_ok |-> lamp_stop && !lamp_run && !traffic_en)
    else $error("stop lamps");
  cold_pair_a: assert property (cold_restart |-> conn_drop) else $error("cold alone");
  resync_boot_a: assert property (sync_req && traffic_en |-> ##[1:2] (conn_drop && !cold_restart))
    else $error("no warm restart");
  blink_lamp_a: assert property (comm_lamp |-> !traffic_en && !cfg_load_ok) else $error("comm lamp");
endmodule : sss_ctrl_checker
bind sss_ctrl sss_ctrl_checker #(.BOOT_CYC(BOOT_CYC)) u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .sync_req(sync_req),
  .sync_done(sync_done), .config_error_byte(config_error_byte), .traffic_en(traffic_en),
  .conn_drop(conn_drop), .cfg_load_ok(cfg_load_ok), .cold_restart(cold_restart),
  .lamp_run(lamp_run), .lamp_stop(lamp_stop), .comm_lamp(comm_lamp));

// ---- testbench/sss_ctrl_test.sv ----
// Purpose: Self-checking bench for the state controller
// Assumes: Shortened boot, switch starts at STOP
// Notes: Restart pulses are counted by a monitor
`timescale 1ns/1ps
module sss_ctrl_test;
  logic clk_sys = 1'b0, rst_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic wb_ack_o, run_switch = 1'b0, res_short = 1'b0, sync_req, sync_done;
  logic [2:0] sync_frame;
  logic [7:0] config_error_byte, e;
  logic traffic_en, conn_drop, cfg_load_ok, cold_restart, lamp_run, lamp_stop, comm_lamp, irq, d, ok;
  int n_mismatch = 0, tests_run = 0, n_drop = 0, n_cold = 0, cyc = 0, d0, c0, hi, lo;
  sss_ctrl #(.BOOT_CYC(200), .HW_CYC(10), .MEM_CYC(20), .DRV_CYC(30), .BLINK_CYC(4)) dut (.clk_sys, .rst_n,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .run_switch,
    .res_short, .sync_req, .sync_frame, .sync_done, .config_error_byte, .traffic_en, .conn_drop,
    .cfg_load_ok, .cold_restart, .lamp_run, .lamp_stop, .comm_lamp, .irq);
  sss_host_model host (.clk_sys, .sync_done, .config_error_byte, .sync_req, .sync_frame);
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (conn_drop === 1'b1) n_drop++;
    if (cold_restart === 1'b1) n_cold++;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  // ******************************
  // Shared tasks
  // ******************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= v;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1);
    chk(32'(n), 32'h2);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wt
  task automatic st(input sss_pkg::sss_state_t s);
    wb(1'b0, sss_pkg::A_STATUS, 32'h0);
    chk({25'h0, q[6:0]}, {25'h0, s});
  endtask : st
  task automatic outs(input logic [3:0] x);
    chk({28'h0, lamp_run, lamp_stop, comm_lamp, traffic_en}, {28'h0, x});
  endtask : outs
  task automatic restarts(input int dn, input int cn);
    chk(32'(n_drop - d0), 32'(dn));
    chk(32'(n_cold - c0), 32'(cn));
  endtask : restarts
  // ******************************
  // Scenarios
  // ******************************
  task automatic t_boot();
    st(sss_pkg::S_HW);
    chk({24'h0, config_error_byte}, 32'h01);
    host.poll(3'h0, ok);
    chk({31'h0, ok}, 32'h1);
    st(sss_pkg::S_STOP);
    wt(1);
    outs(4'b0100);
  endtask : t_boot
  task automatic t_frames();
    wb(1'b1, sss_pkg::A_FRAMES, 32'h3);
    wb(1'b0, sss_pkg::A_FRAMES, 32'h0);
    chk(q, 32'h3);
    host.sync(3'h1, e, d);
    chk({23'h0, d, e}, 32'h100);
    host.sync(3'h5, e, d);
    chk({24'h0, e}, 32'h02);
    wb(1'b0, sss_pkg::A_STATUS, 32'h0);
    chk(q & 32'h00FF_0200, 32'h0003_0200);
  endtask : t_frames
  task automatic t_cold();
    d0 = n_drop;
    c0 = n_cold;
    @(posedge clk_sys);
    res_short <= 1'b1;
    run_switch <= 1'b1;
    wt(8);
    restarts(1, 1);
    wb(1'b0, sss_pkg::A_STATUS, 32'h0);
    chk(q & 32'h00FF_0000, 32'h0);
    hi = 0;
    lo = 0;
    repeat (300) begin
      @(posedge clk_sys);
      if (comm_lamp === 1'b1) hi++;
      else lo++;
    end
    chk(32'(hi > 0 && lo > 0), 32'h1);
    st(sss_pkg::S_JOB);
    res_short <= 1'b0;
    host.poll(3'h0, ok);
    st(sss_pkg::S_IDLE);
    wt(1);
    outs(4'b1100);
    host.sync(3'h1, e, d);
    wt(2);
    st(sss_pkg::S_RUN);
    outs(4'b1001);
    chk({31'h0, cfg_load_ok}, 32'h0);
    wb(1'b1, sss_pkg::A_FRAMES, 32'h7);
    wb(1'b0, sss_pkg::A_FRAMES, 32'h0);
    chk(q, 32'h3);
  endtask : t_cold
  task automatic t_resync();
    d0 = n_drop;
    c0 = n_cold;
    host.sync(3'h0, e, d);
    wt(3);
    restarts(1, 0);
    chk({31'h0, traffic_en}, 32'h0);
    host.poll(3'h0, ok);
    host.sync(3'h1, e, d);
    wt(2);
    st(sss_pkg::S_RUN);
  endtask : t_resync
  task automatic t_tool();
    wb(1'b1, sss_pkg::A_CTRL, 32'h1);
    wt(2);
    st(sss_pkg::S_STOP);
    outs(4'b0100);
    chk({31'h0, cfg_load_ok}, 32'h1);
    d0 = n_drop;
    c0 = n_cold;
    wb(1'b1, sss_pkg::A_CTRL, 32'h0);
    wb(1'b1, sss_pkg::A_CTRL, 32'h2);
    wt(3);
    restarts(2, 0);
  endtask : t_tool
  task automatic t_irq();
    wb(1'b0, sss_pkg::A_IRQ_STAT, 32'h0);
    chk(q & 32'h4, 32'h4);
    wb(1'b1, sss_pkg::A_IRQ_MASK, 32'h4);
    wt(2);
    chk({31'h0, irq}, 32'h1);
    wb(1'b1, sss_pkg::A_IRQ_MASK, 32'h0);
    wt(2);
    chk({31'h0, irq}, 32'h0);
    wb(1'b1, sss_pkg::A_IRQ_STAT, 32'hF);
    wb(1'b1, sss_pkg::A_IRQ_MASK, 32'hF);
    wt(2);
    chk({31'h0, irq}, 32'h0);
    wb(1'b0, 8'h3C, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, sss_pkg::A_ERRBYTE, 32'h0);
    chk(q, 32'h1);
  endtask : t_irq
  task automatic wrap_up();
    $display("Mismatches %0d, comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_boot();
    t_frames();
    t_cold();
    t_resync();
    t_tool();
    t_irq();
    wrap_up();
  end
endmodule : sss_ctrl_test
